// ==== tb/pdm_pad_model.sv ====
// pad and outside-line model for one eight-pin port
`timescale 1ns/100ps
`default_nettype none
module pdm_pad_model (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [7:0] out_enable,
	input wire logic [7:0] out_value,
	input wire logic [7:0] pull_on,
	input wire logic [7:0] ext_enable,
	input wire logic [7:0] ext_value,
	output logic [7:0] pin_level
);
	logic [7:0] last_reg;
	// pull-up or inverse of last level when nobody drives
	assign pin_level = (out_enable & out_value) | (~out_enable & ext_enable & ext_value)
		| (~out_enable & ~ext_enable & (pull_on | ~last_reg));
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			last_reg <= 8'h00;
		end else begin
			last_reg <= pin_level;
		end
	end
endmodule
`default_nettype wire

// ==== tb/pdm_port_props.sv ====
// concurrent checks on the port d/e override block
`timescale 1ns/100ps
`default_nettype none
module pdm_port_props (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [7:0] porte_value,
	input wire logic global_pullup_disable,
	input wire logic legacy_mode,
	input wire logic [7:0] portd_pin_in,
	input wire logic two_wire_enable,
	input wire logic two_wire_scl_pull_low,
	input wire logic serial1_tx_enable,
	input wire logic serial1_tx_data,
	input wire logic serial0_sync_select,
	input wire logic serial0_tx_enable,
	input wire logic serial0_rx_enable,
	input wire logic serial0_tx_data,
	input wire logic serial0_clock_out,
	input wire logic prog_mode,
	input wire logic [7:0] ext_interrupt_enable,
	input wire logic [7:0] portd_pullup,
	input wire logic [7:0] portd_out_enable,
	input wire logic [7:0] portd_out_value,
	input wire logic [7:0] portd_input_enable,
	input wire logic [7:0] porte_pullup,
	input wire logic [7:0] porte_out_enable,
	input wire logic [7:0] porte_out_value,
	input wire logic [7:0] porte_input_enable,
	input wire logic two_wire_slew_enable,
	input wire logic two_wire_scl_in,
	input wire logic timer3_count_clock,
	input wire logic timer3_capture_input,
	input wire logic serial0_ext_clock
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	sequence scl_quiet_low;
		(!portd_pin_in[0] && !two_wire_scl_in) [*4];
	endsequence
	sequence scl_glitch;
		scl_quiet_low ##1 portd_pin_in[0] ##1 !portd_pin_in[0];
	endsequence
	tx0_pin_a: assert property (
		serial0_tx_enable && !prog_mode |=> porte_out_enable[1] && !porte_pullup[1]
		&& porte_out_value[1] == $past(serial0_tx_data)) else $error("pe1 transmit override wrong");
	rx0_pin_a: assert property (
		serial0_rx_enable |=> !porte_out_enable[0]
		&& porte_pullup[0] == ($past(porte_value[0]) && !$past(global_pullup_disable)))
		else $error("pe0 receive override wrong");
	tx1_pin_a: assert property (
		serial1_tx_enable |=> portd_out_enable[3] && !portd_pullup[3]
		&& portd_out_value[3] == $past(serial1_tx_data)) else $error("pd3 transmit override wrong");
	pullup_kill_a: assert property (
		global_pullup_disable |=> portd_pullup == 8'h00 && porte_pullup == 8'h00)
		else $error("pull-up on while globally disabled");
	irq_input_a: assert property (
		1'b1 |=> portd_input_enable[3:0] == $past(ext_interrupt_enable[3:0])
		&& porte_input_enable[7:4] == $past(ext_interrupt_enable[7:4]))
		else $error("input enable does not follow interrupt enable");
	scl_drive_a: assert property (
		(two_wire_enable && two_wire_scl_pull_low) [*6] |-> portd_out_enable[0]
		&& portd_out_value[1:0] == 2'b00 && two_wire_slew_enable) else $error("scl not pulled low");
	scl_release_a: assert property (
		(two_wire_enable && !two_wire_scl_pull_low) [*6] |-> !portd_out_enable[0])
		else $error("scl driven while released");
	scl_spike_a: assert property (
		scl_glitch |=> (!two_wire_scl_in) [*2]) else $error("short pulse reached scl input");
	legacy_cut_a: assert property (
		legacy_mode |=> !timer3_count_clock && !timer3_capture_input && !serial0_ext_clock)
		else $error("legacy mode left a timer3 or clock input live");
	clk0_out_a: assert property (
		serial0_sync_select && !legacy_mode |=> porte_out_value[2] == $past(serial0_clock_out))
		else $error("pe2 clock value wrong");
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking bench for the port d/e override block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
	$display("mismatch at %0t: got %h expected %h", $time, a, b); end end
`define ALLIN {portd_value, portd_direction, porte_value, porte_direction, \
	global_pullup_disable, legacy_mode, two_wire_enable, two_wire_sda_pull_low, \
	two_wire_scl_pull_low, serial1_sync_select, serial1_tx_enable, serial1_rx_enable, \
	serial1_tx_data, serial1_clock_out, serial0_sync_select, serial0_tx_enable, \
	serial0_rx_enable, serial0_tx_data, serial0_clock_out, timer3_compare_en_a, \
	timer3_compare_en_b, timer3_compare_en_c, timer3_compare_out_a, timer3_compare_out_b, \
	timer3_compare_out_c, prog_mode, prog_serial_out, ext_interrupt_enable, \
	pd_ext_en, pd_ext_val, pe_ext_en, pe_ext_val}
module tb_top;
	logic clk_sys, nrst, global_pullup_disable, legacy_mode, two_wire_enable;
	logic two_wire_sda_pull_low, two_wire_scl_pull_low, prog_mode, prog_serial_out;
	logic serial1_sync_select, serial1_tx_enable, serial1_rx_enable, serial1_tx_data;
	logic serial1_clock_out, serial0_sync_select, serial0_tx_enable, serial0_rx_enable;
	logic serial0_tx_data, serial0_clock_out, timer3_compare_en_a, timer3_compare_en_b;
	logic timer3_compare_en_c, timer3_compare_out_a, timer3_compare_out_b;
	logic timer3_compare_out_c, two_wire_slew_enable, two_wire_scl_in, two_wire_sda_in;
	logic timer2_count_clock, timer1_count_clock, timer1_capture_input, timer3_count_clock;
	logic timer3_capture_input, serial1_receive_pin, serial1_ext_clock, serial0_receive_pin;
	logic serial0_ext_clock, prog_serial_in, comparator_pos_input, comparator_neg_input;
	logic [7:0] portd_value, portd_direction, porte_value, porte_direction;
	logic [7:0] portd_pin_in, porte_pin_in, ext_interrupt_enable, ext_interrupt_in;
	logic [7:0] portd_pullup, portd_out_enable, portd_out_value, portd_input_enable;
	logic [7:0] porte_pullup, porte_out_enable, porte_out_value, porte_input_enable;
	logic [7:0] pd_ext_en, pd_ext_val, pe_ext_en, pe_ext_val;
	int fails = 0;
	int total_checks = 0;
	int cycles = 0;
	pdm_port_mux u_dut (.*);
	pdm_pad_model u_pad_d (.clk_sys, .nrst, .out_enable(portd_out_enable),
		.out_value(portd_out_value), .pull_on(portd_pullup), .ext_enable(pd_ext_en),
		.ext_value(pd_ext_val), .pin_level(portd_pin_in));
	pdm_pad_model u_pad_e (.clk_sys, .nrst, .out_enable(porte_out_enable),
		.out_value(porte_out_value), .pull_on(porte_pullup), .ext_enable(pe_ext_en),
		.ext_value(pe_ext_val), .pin_level(porte_pin_in));
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// a hang in any scenario ends the run here
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 2000) begin
			fails++;
			stop_test();
		end
	end
	task automatic go(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic clear;
		@(posedge clk_sys);
		`ALLIN <= '0;
		go(3);
	endtask
	task automatic t_pullups;
		@(posedge clk_sys);
		portd_value <= 8'hf0;
		portd_direction <= 8'h30;
		porte_value <= 8'h0f;
		go(3);
		`CHK(portd_pullup, 8'hc0)
		`CHK(porte_pullup, 8'h0f)
		@(posedge clk_sys);
		global_pullup_disable <= 1'b1;
		go(3);
		`CHK({portd_pullup, porte_pullup}, 16'h0000)
		clear();
		$display("pullups done");
	endtask
	task automatic t_serial0;
		@(posedge clk_sys);
		porte_direction <= 8'h01;
		porte_value <= 8'h01;
		{serial0_rx_enable, serial0_tx_enable, serial0_tx_data} <= 3'b111;
		go(3);
		`CHK(porte_out_enable[1:0], 2'b10)
		`CHK(porte_out_value[1], 1'b1)
		`CHK(porte_pullup[1:0], 2'b01)
		@(posedge clk_sys);
		{prog_mode, prog_serial_out} <= 2'b10;
		{pe_ext_en, pe_ext_val} <= 16'h0101;
		go(3);
		`CHK(porte_out_value[1], 1'b0)
		`CHK({prog_serial_in, serial0_receive_pin}, 2'b11)
		clear();
		$display("serial0 done");
	endtask
	task automatic t_serial1;
		@(posedge clk_sys);
		{portd_direction, portd_value} <= 16'h0404;
		{serial1_rx_enable, serial1_tx_enable, serial1_tx_data} <= 3'b111;
		{serial1_sync_select, serial1_clock_out} <= 2'b11;
		go(3);
		`CHK(portd_out_enable[3:2], 2'b10)
		`CHK(portd_out_value[3], 1'b1)
		`CHK(portd_pullup[3:2], 2'b01)
		`CHK(serial1_receive_pin, 1'b1)
		`CHK(portd_out_value[5], 1'b1)
		clear();
		$display("serial1 done");
	endtask
	task automatic t_two_wire;
		@(posedge clk_sys);
		{two_wire_enable, two_wire_scl_pull_low, two_wire_sda_pull_low} <= 3'b111;
		portd_value <= 8'h03;
		go(6);
		`CHK(portd_out_enable[1:0], 2'b11)
		`CHK(portd_out_value[1:0], 2'b00)
		`CHK(portd_pullup[1:0], 2'b11)
		`CHK(two_wire_slew_enable, 1'b1)
		@(posedge clk_sys);
		{two_wire_scl_pull_low, two_wire_sda_pull_low} <= 2'b00;
		{pd_ext_en, pd_ext_val} <= 16'h0300;
		go(6);
		`CHK(portd_out_enable[1:0], 2'b00)
		`CHK({two_wire_sda_in, two_wire_scl_in}, 2'b00)
		@(posedge clk_sys);
		pd_ext_val <= 8'h01;
		@(posedge clk_sys);
		pd_ext_val <= 8'h00;
		go(4);
		`CHK(two_wire_scl_in, 1'b0)
		@(posedge clk_sys);
		pd_ext_val <= 8'h03;
		go(6);
		`CHK({two_wire_sda_in, two_wire_scl_in}, 2'b11)
		clear();
		$display("two-wire done");
	endtask
	task automatic t_ints;
		@(posedge clk_sys);
		ext_interrupt_enable <= 8'ha5;
		{pd_ext_en, pd_ext_val, pe_ext_en, pe_ext_val} <= 32'hff05_ffa0;
		go(3);
		`CHK({porte_input_enable, portd_input_enable}, 16'ha005)
		`CHK(ext_interrupt_in & 8'ha5, 8'ha5)
		clear();
		$display("interrupts done");
	endtask
	task automatic t_timers;
		@(posedge clk_sys);
		{pd_ext_en, pd_ext_val, pe_ext_en, pe_ext_val} <= 32'hffd0_cec8;
		// software makes pe5 and pe4 outputs
		porte_direction <= 8'h30;
		{timer3_compare_en_a, timer3_compare_en_b, timer3_compare_en_c} <= 3'b111;
		{timer3_compare_out_a, timer3_compare_out_b, timer3_compare_out_c} <= 3'b101;
		go(3);
		`CHK({timer2_count_clock, timer1_count_clock, timer1_capture_input}, 3'b111)
		`CHK({timer3_capture_input, timer3_count_clock}, 2'b11)
		`CHK({comparator_neg_input, comparator_pos_input}, 2'b10)
		`CHK(porte_out_value[5:3], 3'b101)
		`CHK(porte_out_enable[5:3], 3'b110)
		@(posedge clk_sys);
		legacy_mode <= 1'b1;
		go(3);
		`CHK({timer3_capture_input, timer3_count_clock}, 2'b00)
		`CHK(porte_out_value[5:3], 3'b000)
		clear();
		$display("timers done");
	endtask
	task automatic t_serial0_ext_clock;
		@(posedge clk_sys);
		{serial0_sync_select, serial0_clock_out} <= 2'b11;
		porte_direction <= 8'h04;
		go(3);
		`CHK(porte_out_enable[2], 1'b1)
		`CHK(porte_out_value[2], 1'b1)
		@(posedge clk_sys);
		{porte_direction, serial0_clock_out} <= 9'h000;
		{pe_ext_en, pe_ext_val} <= 16'h0404;
		go(3);
		`CHK({porte_out_enable[2], serial0_ext_clock}, 2'b01)
		clear();
		$display("serial0 clock done");
	endtask
	initial begin
		nrst = 1'b0;
		`ALLIN = '0;
		go(12);
		`CHK({two_wire_sda_in, two_wire_scl_in}, 2'b11)
		nrst = 1'b1;
		t_pullups();
		t_serial0();
		t_serial1();
		t_two_wire();
		t_ints();
		t_timers();
		t_serial0_ext_clock();
		stop_test();
	end
endmodule
bind pdm_port_mux pdm_port_props u_props (.*);
`default_nettype wire

// ==== verilog/pdm_pkg.sv ====
// constants and types shared by the port d/e override block
package pdm_pkg;
	// two-wire spike filter: reject pulses shorter than this
	localparam int SPIKE_NS = 50;
	localparam int CLK_NS = 40;
	// least time rounds up to whole cycles
	localparam int SPIKE_CYCLES_INT = (SPIKE_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [2:0] SPIKE_CYCLES = SPIKE_CYCLES_INT[2:0];
	// slew-limited open-drain: hold a new level this many cycles before it reaches the pin
	localparam logic [2:0] SLEW_CYCLES = 3'h2;
	localparam int PIN_COUNT = 8;
	// pin positions
	localparam int PD_SCL = 0;
	localparam int PD_SDA = 1;
	localparam int PD_RX1 = 2;
	localparam int PD_TX1 = 3;
	localparam int PD_SERIAL1_EXT_CLOCK = 5;
	localparam int PE_RX0 = 0;
	localparam int PE_TX0 = 1;
	localparam int PE_SERIAL0_EXT_CLOCK = 2;
	localparam int PE_OCA = 3;
	localparam int PE_OCB = 4;
	localparam int PE_OCC = 5;
	localparam int PE_T3 = 6;
	localparam int PE_TIMER3_CAPTURE_INPUT = 7;
	// reset values of registered outputs
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic RST_BIT = 1'b0;
	localparam logic RST_FILT = 1'b1;
	typedef enum logic [1:0] {
		PDM_IDLE = 2'b00,
		PDM_HOLD = 2'b01
	} pdm_filt_state_type;
endpackage

// ==== verilog/pdm_port_mux.sv ====
// pin override logic for port d and port e alternate functions
`timescale 1ns/100ps
`default_nettype none
module pdm_port_mux
	import pdm_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	// port register settings
	input wire logic [7:0] portd_value,
	input wire logic [7:0] portd_direction,
	input wire logic [7:0] porte_value,
	input wire logic [7:0] porte_direction,
	input wire logic global_pullup_disable,
	input wire logic legacy_mode,
	// pad inputs
	input wire logic [7:0] portd_pin_in,
	input wire logic [7:0] porte_pin_in,
	// two-wire interface
	input wire logic two_wire_enable,
	input wire logic two_wire_sda_pull_low,
	input wire logic two_wire_scl_pull_low,
	// serial ports
	input wire logic serial1_sync_select,
	input wire logic serial1_tx_enable,
	input wire logic serial1_rx_enable,
	input wire logic serial1_tx_data,
	input wire logic serial1_clock_out,
	input wire logic serial0_sync_select,
	input wire logic serial0_tx_enable,
	input wire logic serial0_rx_enable,
	input wire logic serial0_tx_data,
	input wire logic serial0_clock_out,
	// timer3 compare outputs
	input wire logic timer3_compare_en_a,
	input wire logic timer3_compare_en_b,
	input wire logic timer3_compare_en_c,
	input wire logic timer3_compare_out_a,
	input wire logic timer3_compare_out_b,
	input wire logic timer3_compare_out_c,
	// serial programming
	input wire logic prog_mode,
	input wire logic prog_serial_out,
	// interrupt enables: [3:0] port d, [7:4] port e
	input wire logic [7:0] ext_interrupt_enable,
	// pad controls
	output logic [7:0] portd_pullup,
	output logic [7:0] portd_out_enable,
	output logic [7:0] portd_out_value,
	output logic [7:0] portd_input_enable,
	output logic [7:0] porte_pullup,
	output logic [7:0] porte_out_enable,
	output logic [7:0] porte_out_value,
	output logic [7:0] porte_input_enable,
	output logic two_wire_slew_enable,
	// peripheral inputs
	output logic [7:0] ext_interrupt_in,
	output logic two_wire_scl_in,
	output logic two_wire_sda_in,
	output logic timer2_count_clock,
	output logic timer1_count_clock,
	output logic timer1_capture_input,
	output logic timer3_count_clock,
	output logic timer3_capture_input,
	output logic serial1_receive_pin,
	output logic serial1_ext_clock,
	output logic serial0_receive_pin,
	output logic serial0_ext_clock,
	output logic prog_serial_in,
	output logic comparator_pos_input,
	output logic comparator_neg_input
);
	logic [7:0] d_pullup_override_enable, d_pullup_override_value, d_direction_override_enable, d_direction_override_value, d_output_value_override_enable, d_output_value_override_value, d_input_enable_override_enable;
	logic [7:0] e_pullup_override_enable, e_pullup_override_value, e_direction_override_enable, e_direction_override_value, e_output_value_override_enable, e_output_value_override_value, e_input_enable_override_enable;
	logic [7:0] d_pu_next, d_oe_next, d_ov_next, d_ie_next;
	logic [7:0] e_pu_next, e_oe_next, e_ov_next, e_ie_next;
	logic scl_filt, sda_filt, scl_slow, sda_slow;
	logic t3_avail;

	// legacy mode removes the timer3 and serial0 clock functions
	// legacy gating
	assign t3_avail = !legacy_mode;

	pdm_spike_filter u_scl_filter (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.raw_in(portd_pin_in[PD_SCL]),
		.hold_cycles(SPIKE_CYCLES),
		.filt_out(scl_filt)
	);

	pdm_spike_filter u_sda_filter (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.raw_in(portd_pin_in[PD_SDA]),
		.hold_cycles(SPIKE_CYCLES),
		.filt_out(sda_filt)
	);

	pdm_slew_limiter u_scl_slew (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.pull_low(two_wire_scl_pull_low),
		.drive_low(scl_slow)
	);

	pdm_slew_limiter u_sda_slew (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.pull_low(two_wire_sda_pull_low),
		.drive_low(sda_slow)
	);

	// port d override table
	always_comb begin
		d_pullup_override_enable = 8'h00;
		d_pullup_override_value = 8'h00;
		d_direction_override_enable = 8'h00;
		d_direction_override_value = 8'h00;
		d_output_value_override_enable = 8'h00;
		d_output_value_override_value = 8'h00;
		d_output_value_override_enable[PD_SERIAL1_EXT_CLOCK] = serial1_sync_select;
		d_output_value_override_value[PD_SERIAL1_EXT_CLOCK] = serial1_clock_out;
		d_pullup_override_enable[PD_TX1] = serial1_tx_enable;
		d_direction_override_enable[PD_TX1] = serial1_tx_enable;
		d_direction_override_value[PD_TX1] = 1'b1;
		d_output_value_override_enable[PD_TX1] = serial1_tx_enable;
		d_output_value_override_value[PD_TX1] = serial1_tx_data;
		d_pullup_override_enable[PD_RX1] = serial1_rx_enable;
		d_pullup_override_value[PD_RX1] = portd_value[PD_RX1] & !global_pullup_disable;
		d_direction_override_enable[PD_RX1] = serial1_rx_enable;
		// two-wire drive 0, direction from drive
		d_pullup_override_enable[PD_SCL] = two_wire_enable;
		d_pullup_override_enable[PD_SDA] = two_wire_enable;
		d_pullup_override_value[PD_SCL] = portd_value[PD_SCL] & !global_pullup_disable;
		d_pullup_override_value[PD_SDA] = portd_value[PD_SDA] & !global_pullup_disable;
		d_direction_override_enable[PD_SCL] = two_wire_enable;
		d_direction_override_enable[PD_SDA] = two_wire_enable;
		d_direction_override_value[PD_SCL] = scl_slow;
		d_direction_override_value[PD_SDA] = sda_slow;
		d_output_value_override_enable[PD_SCL] = two_wire_enable;
		d_output_value_override_enable[PD_SDA] = two_wire_enable;
		d_input_enable_override_enable = {4'h0, ext_interrupt_enable[3:0]};
	end

	// port e override table
	always_comb begin
		e_pullup_override_enable = 8'h00;
		e_pullup_override_value = 8'h00;
		e_direction_override_enable = 8'h00;
		e_direction_override_value = 8'h00;
		e_output_value_override_enable = 8'h00;
		e_output_value_override_value = 8'h00;
		e_output_value_override_enable[PE_OCC] = timer3_compare_en_c & t3_avail;
		e_output_value_override_value[PE_OCC] = timer3_compare_out_c;
		e_output_value_override_enable[PE_OCB] = timer3_compare_en_b & t3_avail;
		e_output_value_override_value[PE_OCB] = timer3_compare_out_b;
		e_output_value_override_enable[PE_OCA] = timer3_compare_en_a & t3_avail;
		e_output_value_override_value[PE_OCA] = timer3_compare_out_a;
		// serial0 clock only in synchronous mode
		e_output_value_override_enable[PE_SERIAL0_EXT_CLOCK] = serial0_sync_select & t3_avail;
		e_output_value_override_value[PE_SERIAL0_EXT_CLOCK] = serial0_clock_out;
		e_pullup_override_enable[PE_TX0] = serial0_tx_enable | prog_mode;
		e_direction_override_enable[PE_TX0] = serial0_tx_enable | prog_mode;
		e_direction_override_value[PE_TX0] = 1'b1;
		e_output_value_override_enable[PE_TX0] = serial0_tx_enable | prog_mode;
		e_output_value_override_value[PE_TX0] = prog_mode ? prog_serial_out : serial0_tx_data;
		e_pullup_override_enable[PE_RX0] = serial0_rx_enable;
		e_pullup_override_value[PE_RX0] = porte_value[PE_RX0] & !global_pullup_disable;
		e_direction_override_enable[PE_RX0] = serial0_rx_enable;
		e_input_enable_override_enable = {ext_interrupt_enable[7:4], 4'h0};
	end

	always_comb begin
		for (int i = 0; i < PIN_COUNT; i++) begin
			d_oe_next[i] = d_direction_override_enable[i] ? d_direction_override_value[i] : portd_direction[i];
			d_ov_next[i] = d_output_value_override_enable[i] ? d_output_value_override_value[i] : portd_value[i];
			d_pu_next[i] = d_pullup_override_enable[i] ? d_pullup_override_value[i]
				: (!portd_direction[i] & portd_value[i] & !global_pullup_disable);
			d_ie_next[i] = d_input_enable_override_enable[i] ? 1'b1 : 1'b0;
			e_oe_next[i] = e_direction_override_enable[i] ? e_direction_override_value[i] : porte_direction[i];
			e_ov_next[i] = e_output_value_override_enable[i] ? e_output_value_override_value[i] : porte_value[i];
			e_pu_next[i] = e_pullup_override_enable[i] ? e_pullup_override_value[i]
				: (!porte_direction[i] & porte_value[i] & !global_pullup_disable);
			e_ie_next[i] = e_input_enable_override_enable[i] ? 1'b1 : 1'b0;
		end
	end

	// pad controls are registered so the pads see clean levels
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			portd_pullup <= RST_BYTE;
			portd_out_enable <= RST_BYTE;
			portd_out_value <= RST_BYTE;
			portd_input_enable <= RST_BYTE;
			porte_pullup <= RST_BYTE;
			porte_out_enable <= RST_BYTE;
			porte_out_value <= RST_BYTE;
			porte_input_enable <= RST_BYTE;
			two_wire_slew_enable <= RST_BIT;
		end else begin
			portd_pullup <= d_pu_next;
			portd_out_enable <= d_oe_next;
			portd_out_value <= d_ov_next;
			portd_input_enable <= d_ie_next;
			porte_pullup <= e_pu_next;
			porte_out_enable <= e_oe_next;
			porte_out_value <= e_ov_next;
			porte_input_enable <= e_ie_next;
			two_wire_slew_enable <= two_wire_enable;
		end
	end

	// peripheral inputs, registered; the filtered copies go to the two-wire logic only
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ext_interrupt_in <= RST_BYTE;
			two_wire_scl_in <= RST_FILT;
			two_wire_sda_in <= RST_FILT;
			timer2_count_clock <= RST_BIT;
			timer1_count_clock <= RST_BIT;
			timer1_capture_input <= RST_BIT;
			timer3_count_clock <= RST_BIT;
			timer3_capture_input <= RST_BIT;
			serial1_receive_pin <= RST_BIT;
			serial1_ext_clock <= RST_BIT;
			serial0_receive_pin <= RST_BIT;
			serial0_ext_clock <= RST_BIT;
			prog_serial_in <= RST_BIT;
			comparator_pos_input <= RST_BIT;
			comparator_neg_input <= RST_BIT;
		end else begin
			ext_interrupt_in[3:0] <= portd_pin_in[3:0];
			ext_interrupt_in[7:4] <= porte_pin_in[7:4];
			two_wire_scl_in <= scl_filt;
			two_wire_sda_in <= sda_filt;
			timer2_count_clock <= portd_pin_in[7];
			timer1_count_clock <= portd_pin_in[6];
			timer1_capture_input <= portd_pin_in[4];
			serial1_ext_clock <= portd_pin_in[PD_SERIAL1_EXT_CLOCK];
			serial1_receive_pin <= portd_pin_in[PD_RX1];
			// timer3 and serial0 clock inputs, blocked in legacy mode
			timer3_capture_input <= porte_pin_in[PE_TIMER3_CAPTURE_INPUT] & t3_avail;
			timer3_count_clock <= porte_pin_in[PE_T3] & t3_avail;
			serial0_ext_clock <= porte_pin_in[PE_SERIAL0_EXT_CLOCK] & t3_avail;
			serial0_receive_pin <= porte_pin_in[PE_RX0];
			prog_serial_in <= porte_pin_in[PE_RX0];
			comparator_neg_input <= porte_pin_in[PE_OCA];
			comparator_pos_input <= porte_pin_in[PE_SERIAL0_EXT_CLOCK];
		end
	end
endmodule
`default_nettype wire

// ==== verilog/pdm_slew_limiter.sv ====
// open-drain slew limiter: pull-down enable changes only after a settle delay
`timescale 1ns/100ps
`default_nettype none
module pdm_slew_limiter
	import pdm_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic pull_low,
	output logic drive_low
);
	logic [2:0] count_reg;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			count_reg <= 3'h0;
			drive_low <= RST_BIT;
		end else if (pull_low == drive_low) begin
			count_reg <= 3'h0;
		end else if (count_reg >= SLEW_CYCLES - 3'h1) begin
			drive_low <= pull_low;
			count_reg <= 3'h0;
		end else begin
			count_reg <= count_reg + 3'h1;
		end
	end
endmodule
`default_nettype wire

// ==== verilog/pdm_spike_filter.sv ====
// glitch filter: passes a level only after it stays stable for a set count
`timescale 1ns/100ps
`default_nettype none
module pdm_spike_filter
	import pdm_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic raw_in,
	input wire logic [2:0] hold_cycles,
	output logic filt_out
);
	pdm_filt_state_type state_reg;
	logic [2:0] count_reg;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_reg <= PDM_IDLE;
			count_reg <= 3'h0;
			filt_out <= RST_FILT;
		end else begin
			case (state_reg)
				PDM_IDLE: begin
					if (raw_in != filt_out) begin
						state_reg <= PDM_HOLD;
						count_reg <= 3'h1;
					end
				end
				PDM_HOLD: begin
					// a pulse that drops back early is discarded
					if (raw_in == filt_out) begin
						state_reg <= PDM_IDLE;
					end else if (count_reg >= hold_cycles) begin
						filt_out <= raw_in;
						state_reg <= PDM_IDLE;
					end else begin
						count_reg <= count_reg + 3'h1;
					end
				end
				default: begin
					state_reg <= PDM_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire
